// [design/fpgb_gpio_bank.v]
// Functional notes
// RL1: each of four ports has eight pins, each settable as input or output on its own.
// RL2: a data register read returns the pad level, not the latch, in any direction.
// RL3: an output pin drives the matching bit of its port's written latch.
// RL4: direction bit 0 means input, 1 means output, and all reset to input.
// RL5: bit n of direction, pull-up and open-drain controls pin n of the same port.
// RL6: pull-up bit 0 leaves the pull-up off (reset), 1 turns it on.
// RL7: a pin that is an output driving low has its pull-up forced off.
// RL8: open-drain bit 0 gives push-pull, 1 drives low only and releases for high.
// RL9: software uses only whole-byte accesses on these registers.
// RL10: software sets ports one to three high before stop or halt.
// RL11: software keeps pull-ups off while the secondary port supply is low.
// RL12: each port decodes data, direction, pull-up, open-drain in sequence, port zero lowest.
// RL13: with the pin-seven select set and pin seven an output, the pin carries the modulator.
// RL14: port-zero inputs given to the converter stop acting as wake or interrupt sources.
// RL15: pad inputs pass a two-stage synchronizer before being read.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "fpgb_defines.vh"
module fpgb_gpio_bank (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // modulator output for port zero pin seven
    input  wire        pwm_in,
    // pads, port zero in the low byte
    input  wire [31:0] pad_in,
    output reg  [31:0] pad_out,
    output reg  [31:0] pad_oe_n,
    output reg  [31:0] pad_pullup_en,
    // port-zero pins still usable as wake or interrupt sources
    output reg  [7:0]  wake_src_en
);

    // per-port control storage, indexed by port number
    reg  [7:0]  latch_q  [0:3];
    reg  [7:0]  dir_q    [0:3];
    reg  [7:0]  pull_q   [0:3];
    reg  [7:0]  od_q     [0:3];
    reg  [7:0]  sel_q;
    reg  [31:0] sync1_q;
    reg  [31:0] sync2_q;
    reg  [1:0]  port_idx;
    reg  [1:0]  reg_kind;
    reg         hit;
    reg         sel_hit;
    wire [31:0] pad_out_d;
    wire [31:0] pad_oe_n_d;
    wire [31:0] pull_d;
    wire [7:0]  wake_d;
    integer     i;

    // address decode: four registers per port in a fixed order
    always @* begin
        hit      = 1'b1;
        sel_hit  = 1'b0;
        port_idx = 2'd0;
        reg_kind = 2'd0;
        case (reg_addr)  // [RL12]
            `FPGB_PORT_ZERO_LATCH:  begin port_idx = 2'd0; reg_kind = 2'd0; end
            `FPGB_PORT_ZERO_DIR:    begin port_idx = 2'd0; reg_kind = 2'd1; end
            `FPGB_PORT_ZERO_PULL:   begin port_idx = 2'd0; reg_kind = 2'd2; end
            `FPGB_PORT_ZERO_OD:     begin port_idx = 2'd0; reg_kind = 2'd3; end
            `FPGB_PORT_ONE_LATCH:   begin port_idx = 2'd1; reg_kind = 2'd0; end
            `FPGB_PORT_ONE_DIR:     begin port_idx = 2'd1; reg_kind = 2'd1; end
            `FPGB_PORT_ONE_PULL:    begin port_idx = 2'd1; reg_kind = 2'd2; end
            `FPGB_PORT_ONE_OD:      begin port_idx = 2'd1; reg_kind = 2'd3; end
            `FPGB_PORT_TWO_LATCH:   begin port_idx = 2'd2; reg_kind = 2'd0; end
            `FPGB_PORT_TWO_DIR:     begin port_idx = 2'd2; reg_kind = 2'd1; end
            `FPGB_PORT_TWO_PULL:    begin port_idx = 2'd2; reg_kind = 2'd2; end
            `FPGB_PORT_TWO_OD:      begin port_idx = 2'd2; reg_kind = 2'd3; end
            `FPGB_PORT_THREE_LATCH: begin port_idx = 2'd3; reg_kind = 2'd0; end
            `FPGB_PORT_THREE_DIR:   begin port_idx = 2'd3; reg_kind = 2'd1; end
            `FPGB_PORT_THREE_PULL:  begin port_idx = 2'd3; reg_kind = 2'd2; end
            `FPGB_PORT_THREE_OD:    begin port_idx = 2'd3; reg_kind = 2'd3; end
            `FPGB_FUNC_SEL:         begin hit = 1'b0; sel_hit = 1'b1; end
            default:                hit = 1'b0;
        endcase
    end

    // register writes; whole bytes only, no bit access exists
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                latch_q[i] <= `FPGB_RST_LATCH;
                dir_q[i]   <= `FPGB_RST_DIR;   // all inputs [RL4]
                pull_q[i]  <= `FPGB_RST_PULL;  // pull-ups off [RL6]
                od_q[i]    <= `FPGB_RST_OD;    // push-pull [RL8]
            end
            sel_q <= `FPGB_RST_SEL;
        end else if (reg_wr) begin  // [RL9]
            if (sel_hit) begin
                sel_q <= reg_wdata;
            end else if (hit) begin
                case (reg_kind)
                    2'd0:    latch_q[port_idx] <= reg_wdata;
                    2'd1:    dir_q[port_idx]   <= reg_wdata;
                    2'd2:    pull_q[port_idx]  <= reg_wdata;
                    default: od_q[port_idx]    <= reg_wdata;
                endcase
            end
        end
    end

    // two flops on every pad before anything reads it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 32'h0000_0000;
            sync2_q <= 32'h0000_0000;
        end else begin
            sync1_q <= pad_in;   // [RL15]
            sync2_q <= sync1_q;
        end
    end

    // read data one cycle after the strobe; only data registers and select read back
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `FPGB_RST_UNMAPPED;
        end else if (reg_rd) begin
            if (sel_hit) begin
                reg_rdata <= sel_q;
            end else if (hit && reg_kind == 2'd0) begin
                reg_rdata <= sync2_q[port_idx*8 +: 8];  // pad level, not latch [RL2]
            end else begin
                reg_rdata <= `FPGB_RST_UNMAPPED;  // write-only and unmapped read zero
            end
        end else begin
            reg_rdata <= `FPGB_RST_UNMAPPED;
        end
    end

    // per-pin drive logic; bit n of each control byte steers pin n
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_pin
            wire out_en = dir_q[g/8][g%8];               // [RL1] [RL4] [RL5]
            wire is_pwm = (g == 7) && sel_q[`FPGB_SEL_PWM_BIT];
            wire val    = is_pwm ? pwm_in : latch_q[g/8][g%8];  // [RL3] [RL13]
            wire odrain = od_q[g/8][g%8];
            // open drain releases the pad instead of driving high
            assign pad_out_d[g]  = val;
            assign pad_oe_n_d[g] = ~(out_en & ~(odrain & val));  // [RL8]
            // pull-up cut while pin drives low, saving static current
            assign pull_d[g] = pull_q[g/8][g%8] & ~(out_en & ~val);  // [RL6] [RL7]
        end
    endgenerate

    // converter pins lose wake/interrupt duty; refs follow either channel
    assign wake_d[1:0] = {2{~sel_q[`FPGB_SEL_ADC0_BIT]}};  // [RL14]
    assign wake_d[3:2] = {2{~sel_q[`FPGB_SEL_ADC1_BIT]}};
    assign wake_d[6:4] = {3{~(sel_q[`FPGB_SEL_ADC0_BIT] | sel_q[`FPGB_SEL_ADC1_BIT])}};
    assign wake_d[7]   = 1'b1;

    // all pad controls registered so outputs come from flops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out       <= 32'h0000_0000;
            pad_oe_n      <= 32'hffff_ffff;
            pad_pullup_en <= 32'h0000_0000;
            wake_src_en   <= 8'hff;
        end else begin
            pad_out       <= pad_out_d;
            pad_oe_n      <= pad_oe_n_d;
            pad_pullup_en <= pull_d;
            wake_src_en   <= wake_d;
        end
    end

endmodule // fpgb_gpio_bank

// [design/fpgb_defines.vh]
`ifndef FPGB_DEFINES_VH
`define FPGB_DEFINES_VH
// register byte addresses on the special function register port
`define FPGB_ADDR_W          8
`define FPGB_PORT_ZERO_LATCH 8'hd2
`define FPGB_PORT_ZERO_DIR   8'hd3
`define FPGB_PORT_ZERO_PULL  8'hd4
`define FPGB_PORT_ZERO_OD    8'hd5
`define FPGB_PORT_ONE_LATCH  8'hd7
`define FPGB_PORT_ONE_DIR    8'hd8
`define FPGB_PORT_ONE_PULL   8'hd9
`define FPGB_PORT_ONE_OD     8'hda
`define FPGB_PORT_TWO_LATCH  8'hdc
`define FPGB_PORT_TWO_DIR    8'hdd
`define FPGB_PORT_TWO_PULL   8'hde
`define FPGB_PORT_TWO_OD     8'hdf
`define FPGB_PORT_THREE_LATCH 8'he8
`define FPGB_PORT_THREE_DIR  8'he9
`define FPGB_PORT_THREE_PULL 8'hea
`define FPGB_PORT_THREE_OD   8'heb
// port-zero function select, placed in an unused slot
`define FPGB_FUNC_SEL        8'hd0
// field positions in the function select register
`define FPGB_SEL_ADC0_BIT    0
`define FPGB_SEL_ADC1_BIT    1
`define FPGB_SEL_PWM_BIT     7
// reset values
`define FPGB_RST_DIR         8'h00
`define FPGB_RST_PULL        8'h00
`define FPGB_RST_OD          8'h00
`define FPGB_RST_LATCH       8'h00
`define FPGB_RST_SEL         8'h00
`define FPGB_RST_UNMAPPED    8'h00
`endif

// [tb/fpgb_gpio_bank_assertions.sv]
`timescale 1ns/100ps
`include "fpgb_defines.vh"
module fpgb_gpio_bank_assertions (
    // clock, reset, register port
    input wire        clk,
    input wire        rst_n,
    input wire [7:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    // pads
    input wire        pwm_in,
    input wire [31:0] pad_in,
    input wire [31:0] pad_out,
    input wire [31:0] pad_oe_n,
    input wire [31:0] pad_pullup_en,
    input wire [7:0]  wake_src_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // pad held long enough to cross the synchronizer
    sequence s_pad_steady;
        ($stable(pad_in[7:0]) && rst_n) [*4];
    endsequence
    a_reset_state: assert property ($rose(rst_n) |-> &pad_oe_n && !pad_pullup_en)
        else $error("pads not idle after reset");
    a_pull_cut: assert property ((~pad_oe_n & ~pad_out & pad_pullup_en) == 32'h0000_0000)
        else $error("pull-up on a pin driving low");
    a_input_release: assert property (reg_wr && reg_addr == `FPGB_PORT_ZERO_DIR |->
        ##3 (pad_oe_n[7:0] | $past(reg_wdata, 3)) == 8'hff) else $error("input pin driven");
    a_latch_drive: assert property (reg_wr && reg_addr == `FPGB_PORT_ONE_LATCH |-> ##3
        ((pad_out[15:8] ^ $past(reg_wdata, 3)) & ~pad_oe_n[15:8]) == 8'h00)
        else $error("driven pin differs from latch");
    a_pull_follow: assert property (reg_wr && reg_addr == `FPGB_PORT_TWO_PULL |-> ##3
        ((pad_pullup_en[23:16] ^ $past(reg_wdata, 3)) & pad_oe_n[23:16]) == 8'h00)
        else $error("pull-up differs from its bit");
    a_addr_refuse: assert property (reg_rd && (reg_addr == `FPGB_PORT_ZERO_DIR ||
        reg_addr == 8'hd6) |=> reg_rdata == 8'h00) else $error("refused read not zero");
    a_pad_read: assert property (s_pad_steady ##0 reg_rd &&
        reg_addr == `FPGB_PORT_ZERO_LATCH |=> reg_rdata == $past(pad_in[7:0]))
        else $error("read differs from pad");
    a_adc_wake: assert property (reg_wr && reg_addr == `FPGB_FUNC_SEL && reg_wdata[0] |->
        ##[3:4] (wake_src_en & 8'h73) == 8'h00) else $error("converter pin still wakes");
endmodule // fpgb_gpio_bank_assertions
bind fpgb_gpio_bank fpgb_gpio_bank_assertions fpgb_gpio_bank_assertions_i (.clk(clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_in(pwm_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
    .wake_src_en(wake_src_en));

// [tb/fpgb_pad_model.sv]
`timescale 1ns/100ps
module fpgb_pad_model (
    // clock for the floating pattern
    input  wire        clk,
    // device and board drive
    input  wire [31:0] pad_out,
    input  wire [31:0] pad_oe_n,
    input  wire [31:0] pad_pullup_en,
    input  wire [31:0] ext_en,
    input  wire [31:0] ext_val,
    output wire [31:0] pad_in
);
    reg [31:0] float_q = 32'h0000_0000;
    // an undriven pin with no pull-up never keeps its last level
    always @(posedge clk) float_q <= ~float_q;
    // device wins, then board, then pull-up, then float
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ((ext_en & ext_val) |
        (~ext_en & (pad_pullup_en | float_q))));
endmodule // fpgb_pad_model

// [tb/fpgb_gpio_bank_tb_top.sv]
`timescale 1ns/100ps
`include "fpgb_defines.vh"
module fpgb_gpio_bank_tb_top;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         pwm_in = 1'b0;
    reg  [31:0] ext_en = 32'h0000_0000;
    reg  [31:0] ext_val = 32'ha5c3_3c5a;
    reg  [7:0]  rd_q;
    wire [7:0]  reg_rdata;
    wire [7:0]  wake_src_en;
    wire [31:0] pad_in, pad_out, pad_oe_n, pad_pullup_en;
    integer     num_errors = 0, num_checks = 0, cyc = 0, p;
    fpgb_gpio_bank fpgb_gpio_bank_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pwm_in(pwm_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup_en(pad_pullup_en), .wake_src_en(wake_src_en));
    fpgb_pad_model fpgb_pad_model_i (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup_en(pad_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    initial forever #10 clk = ~clk;
    // hang guard, the tests need under a hundred cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    // latch address of a port, the other three follow it
    function [7:0] lat(input integer q);
        lat = (q == 3) ? 8'he8 : 8'hd2 + q[7:0] * 8'h05;
    endfunction
    task wr(input [7:0] a, input [7:0] d); // whole bytes only
        begin
            @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
            @(posedge clk) reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
            @(posedge clk) reg_rd <= 1'b0;
            #1 rd_q = reg_rdata;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // reset away from the edge, then one test after another
    initial begin
        repeat (10) @(posedge clk);
        #3 rst_n = 1'b1;
        @(posedge clk) #1 chk(pad_oe_n | pad_pullup_en, 32'hffff_ffff);
        chk({24'h00_0000, wake_src_en}, 32'h0000_00ff);
        ext_en <= 32'hffff_ffff;
        repeat (4) @(posedge clk);
        for (p = 0; p < 4; p = p + 1) begin
            rd(lat(p));
            chk({24'h00_0000, rd_q}, {24'h00_0000, ext_val[8*p +: 8]});
        end
        $display("test inputs done");
        ext_en <= 32'hf0f0_f0f0;
        for (p = 0; p < 4; p = p + 1) begin
            wr(lat(p), 8'h96);
            wr(lat(p) + 8'h01, 8'h0f);
            wr(lat(p) + 8'h02, 8'hff);
        end
        repeat (2) @(posedge clk) #1 chk(pad_oe_n, 32'hf0f0_f0f0);
        chk(pad_out & 32'h0f0f_0f0f, 32'h0606_0606);
        chk(pad_pullup_en, 32'hf6f6_f6f6);
        rd(lat(1));
        chk({24'h00_0000, rd_q}, 32'h0000_0036);
        wr(`FPGB_PORT_ONE_OD, 8'h0f);
        wr(8'hd6, 8'hff);
        rd(lat(1));
        chk({24'h00_0000, rd_q}, 32'h0000_0036);
        chk(pad_oe_n, 32'hf0f0_f6f0);
        rd(`FPGB_PORT_ZERO_DIR);
        chk({24'h00_0000, rd_q}, 32'h0000_0000);
        $display("test drive done");
        wr(`FPGB_FUNC_SEL, 8'h81);
        wr(`FPGB_PORT_ZERO_DIR, 8'h80);
        for (p = 0; p < 2; p = p + 1) begin
            @(posedge clk) pwm_in <= p[0];
            repeat (3) @(posedge clk) #1 chk({31'h0, pad_out[7]}, {31'h0, p[0]});
        end
        chk({24'h00_0000, wake_src_en & 8'h7f}, 32'h0000_000c);
        rd(`FPGB_FUNC_SEL);
        chk({24'h00_0000, rd_q}, 32'h0000_0081);
        for (p = 1; p < 4; p = p + 1) begin
            wr(lat(p) + 8'h01, 8'hff);
            wr(lat(p), 8'hff);
        end
        wr(8'hea, 8'h00);
        repeat (2) @(posedge clk) #1 chk(pad_in & 32'hffff_ff00, 32'hffff_ff00);
        chk(pad_pullup_en & 32'hff00_0000, 32'h0000_0000);
        $display("test park done");
        end_sim;
    end
endmodule // fpgb_gpio_bank_tb_top
